/* File: sysctl_map.vh */
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: byte-addressed plain register port, word-aligned 8-bit offsets
// Notes: included by the safety control logic and its watchdog
`ifndef SYSCTL_MAP_VH
`define SYSCTL_MAP_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFF_NMI_FLAG_SET    8'h00
`define OFF_NMI_FLAG_FORCE  8'h04
`define OFF_NMI_FLAG_CLEAR  8'h08
`define OFF_NMI_SHADOW      8'h0C
`define OFF_CLK_GATE        8'h10
`define OFF_CLK_GATE_LOCK   8'h14
`define OFF_SOFT_RESET      8'h18
`define OFF_SIM_RESET       8'h1C
`define OFF_RESET_CAUSE     8'h20
`define OFF_RESET_CAUSE_CLR 8'h24
`define OFF_MISSING_CLK     8'h28
`define OFF_PLL_CTRL        8'h2C
`define OFF_WD_CTRL         8'h30
`define OFF_WD_KEY          8'h34
`define OFF_WD_WINDOW       8'h38
`define OFF_IRQ_STATUS      8'h3C
`define OFF_IRQ_CLEAR       8'h40
`define OFF_IRQ_ENABLE      8'h44

// ----------------------------------------------------------------------
// nmi flag bits
// ----------------------------------------------------------------------
`define NMI_CLOCK_FAIL  0
`define NMI_MISSING_CLK 1
`define NMI_EXT_ERROR   2
`define NMI_WIDTH       3

// ----------------------------------------------------------------------
// reset cause bits
// ----------------------------------------------------------------------
`define CAUSE_POR      0
`define CAUSE_EXT_PIN  1
`define CAUSE_WATCHDOG 2
`define CAUSE_SIM_SYS  3
`define CAUSE_SIM_EXT  4
`define CAUSE_WIDTH    5

// ----------------------------------------------------------------------
// control fields and keys
// ----------------------------------------------------------------------
`define SIM_SYS_BIT     0
`define SIM_EXT_BIT     1
`define MCD_OSC_DISCONNECT_BIT_BIT  0
`define MCD_DISABLE_BIT 1
`define MCD_STATUS_BIT  2
`define PLL_LOCK_BIT    2
`define WD_INT_SEL_BIT  0
`define WD_DISABLE_BIT  1
`define WD_KEY_FIRST    8'h55
`define WD_KEY_SECOND   8'hAA
`define IRQ_NMI         0
`define IRQ_WD          1
`define IRQ_PLL_UNLOCK  2
`define IRQ_WIDTH       3

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define CLK_GATE_RST    16'h0000
`define WD_UPPER_RST    8'hFF
`define WD_LOWER_RST    8'h00
`define WARM_HOLD_CYC   4'h8
`define WD_PRESCALE     8'h40

`endif

/* File: sysctl_reset_nmi_safety.v */
// Purpose: reset, nmi shadow, clock gate and safety test control
// Assumes: por_b is the cold reset, rst_b the warm device reset
// Notes: warm reset requests leave through warm_reset_req_r
//
// Local design decisions: the strobed register port and the register offsets.

`include "sysctl_map.vh"

module sysctl_reset_nmi_safety #(
  parameter N_PERIPH = 16,
  parameter WD_W = 8
) (
  input wire core_clk,
  input wire rst_b,
  input wire por_b,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [31:0] rdata_r,
  input wire ext_pin_reset,
  input wire pll_ref_clk_lost,
  input wire pll_freq_drift,
  input wire pll_locked_raw,
  input wire critical_error,
  output wire [N_PERIPH-1:0] periph_clk_en,
  output wire [N_PERIPH-1:0] periph_reset,
  output reg warm_reset_req_r,
  output reg external_reset_pin_oe_r,
  output wire external_reset_pin_o,
  output wire pll_lock,
  output wire sysclk_on_pll,
  output wire error_status_pin,
  output wire nmi,
  output wire irq
);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  reg [`NMI_WIDTH-1:0] nmi_flag_set_r;
  reg [`NMI_WIDTH-1:0] nmi_shadow_r;
  reg [N_PERIPH-1:0] periph_clock_gate_ctrl_r;
  reg gate_lock_r;
  reg [N_PERIPH-1:0] periph_soft_reset_ctrl_r;
  reg [`CAUSE_WIDTH-1:0] reset_cause_latch_r;
  reg osc_disconnect_r;
  reg mcd_disable_r;
  reg missing_clock_status_r;
  reg [1:0] pll_ctrl_r;
  reg pll_lock_r;
  reg wd_int_sel_r;
  reg wd_disable_r;
  reg [WD_W-1:0] wd_lower_r;
  reg [WD_W-1:0] wd_upper_r;
  reg [`IRQ_WIDTH-1:0] irq_status_r;
  reg [`IRQ_WIDTH-1:0] irq_enable_r;
  reg [3:0] warm_cnt_r;
  reg warm_pend_r;
  reg ext_pend_r;
  reg [1:0] pend_src_r;
  reg ext_seen_r;
  reg por_seen_r;

  wire wr_hit_force = wr_en && addr == `OFF_NMI_FLAG_FORCE;
  wire wr_hit_sim = wr_en && addr == `OFF_SIM_RESET;
  wire [`NMI_WIDTH-1:0] nmi_event;
  wire [`IRQ_WIDTH-1:0] irq_event;
  wire wd_irq;
  wire wd_reset;
  wire [WD_W-1:0] wd_count;
  wire mcd_trip = !mcd_disable_r && (osc_disconnect_r || pll_ref_clk_lost);

  // ----------------------------------------------------------------------
  // nmi flags and shadow
  // ----------------------------------------------------------------------
  // forced clock fail
  assign nmi_event[`NMI_CLOCK_FAIL] = wr_hit_force && wdata[`NMI_CLOCK_FAIL];
  assign nmi_event[`NMI_MISSING_CLK] = mcd_trip ||
    (wr_hit_force && wdata[`NMI_MISSING_CLK]);
  assign nmi_event[`NMI_EXT_ERROR] = critical_error ||
    (wr_hit_force && wdata[`NMI_EXT_ERROR]);

  // set wins over clear so no event is lost
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_flag_set_r <= {`NMI_WIDTH{1'b0}};
    end else begin
      nmi_flag_set_r <= (nmi_flag_set_r &
        ~((wr_en && addr == `OFF_NMI_FLAG_CLEAR) ?
          wdata[`NMI_WIDTH-1:0] : {`NMI_WIDTH{1'b0}})) | nmi_event;
    end
  end

  always @(posedge core_clk or negedge por_b) begin
    if (!por_b) begin
      nmi_shadow_r <= {`NMI_WIDTH{1'b0}};
    end else if (warm_pend_r && warm_cnt_r == 4'h0) begin
      nmi_shadow_r <= nmi_flag_set_r;
    end
  end

  assign nmi = |nmi_flag_set_r;
  assign error_status_pin = |nmi_flag_set_r;

  // ----------------------------------------------------------------------
  // peripheral gate and soft reset
  // ----------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      periph_clock_gate_ctrl_r <= `CLK_GATE_RST;
      gate_lock_r <= 1'b0;
      periph_soft_reset_ctrl_r <= {N_PERIPH{1'b0}};
    end else begin
      if (wr_en && addr == `OFF_CLK_GATE && !gate_lock_r) begin
        periph_clock_gate_ctrl_r <= wdata[N_PERIPH-1:0];
      end
      // lock only clears by reset, a write of zero is ignored
      if (wr_en && addr == `OFF_CLK_GATE_LOCK && wdata[0]) begin
        gate_lock_r <= 1'b1;
      end
      if (wr_en && addr == `OFF_SOFT_RESET) begin
        periph_soft_reset_ctrl_r <= wdata[N_PERIPH-1:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N_PERIPH; gi = gi + 1) begin : g_periph
      assign periph_clk_en[gi] = periph_clock_gate_ctrl_r[gi];
      assign periph_reset[gi] = periph_soft_reset_ctrl_r[gi];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // simulated reset sequencing
  // ----------------------------------------------------------------------
  // software or watchdog reset request
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      warm_pend_r <= 1'b0;
      ext_pend_r <= 1'b0;
      pend_src_r <= 2'h0;
      warm_cnt_r <= 4'h0;
      warm_reset_req_r <= 1'b0;
      external_reset_pin_oe_r <= 1'b0;
    end else if (!warm_pend_r) begin
      if (wr_hit_sim && (wdata[`SIM_SYS_BIT] || wdata[`SIM_EXT_BIT])) begin
        warm_pend_r <= 1'b1;
        ext_pend_r <= wdata[`SIM_EXT_BIT];
        pend_src_r <= wdata[`SIM_EXT_BIT] ? 2'h2 : 2'h1;
      end else if (wd_reset) begin
        warm_pend_r <= 1'b1;
        pend_src_r <= 2'h3;
      end
    end else if (warm_cnt_r != `WARM_HOLD_CYC) begin
      // shadow copied at count zero, so reset lands after the snapshot
      warm_cnt_r <= warm_cnt_r + 4'h1;
    end else begin
      warm_reset_req_r <= 1'b1;
      external_reset_pin_oe_r <= ext_pend_r;
    end
  end

  assign external_reset_pin_o = 1'b0; // open drain, drives low only

  // ----------------------------------------------------------------------
  // reset cause latch
  // ----------------------------------------------------------------------
  // latch reset cause
  always @(posedge core_clk or negedge por_b) begin
    if (!por_b) begin
      reset_cause_latch_r <= {`CAUSE_WIDTH{1'b0}};
      ext_seen_r <= 1'b0;
      por_seen_r <= 1'b0;
    end else begin
      por_seen_r <= 1'b1;
      ext_seen_r <= ext_pin_reset;
      reset_cause_latch_r <= (reset_cause_latch_r &
        ~((wr_en && addr == `OFF_RESET_CAUSE_CLR) ?
          wdata[`CAUSE_WIDTH-1:0] : {`CAUSE_WIDTH{1'b0}})) |
        {warm_pend_r && warm_cnt_r == 4'h0 && pend_src_r == 2'h2,
         warm_pend_r && warm_cnt_r == 4'h0 && pend_src_r == 2'h1,
         warm_pend_r && warm_cnt_r == 4'h0 && pend_src_r == 2'h3,
         ext_pin_reset && !ext_seen_r,
         !por_seen_r};
    end
  end

  // ----------------------------------------------------------------------
  // missing clock and pll
  // ----------------------------------------------------------------------
  // detector on by default
  always @(posedge core_clk or negedge por_b) begin
    if (!por_b) begin
      mcd_disable_r <= 1'b0;
      osc_disconnect_r <= 1'b0;
      missing_clock_status_r <= 1'b0;
    end else begin
      if (wr_en && addr == `OFF_MISSING_CLK) begin
        osc_disconnect_r <= wdata[`MCD_OSC_DISCONNECT_BIT_BIT];
        mcd_disable_r <= wdata[`MCD_DISABLE_BIT];
      end
      if (mcd_trip) begin
        missing_clock_status_r <= 1'b1;
      end else if (wr_en && addr == `OFF_MISSING_CLK &&
                   wdata[`MCD_STATUS_BIT]) begin
        missing_clock_status_r <= 1'b0;
      end
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pll_ctrl_r <= 2'h0;
      pll_lock_r <= 1'b0;
    end else begin
      if (wr_en && addr == `OFF_PLL_CTRL) begin
        pll_ctrl_r <= wdata[1:0];
      end
      pll_lock_r <= pll_ctrl_r[0] && pll_locked_raw && !pll_freq_drift;
    end
  end

  assign pll_lock = pll_lock_r;
  assign sysclk_on_pll = pll_ctrl_r[1] && pll_lock_r;

  // ----------------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_int_sel_r <= 1'b0;
      wd_disable_r <= 1'b0;
      wd_lower_r <= `WD_LOWER_RST;
      wd_upper_r <= `WD_UPPER_RST;
    end else begin
      if (wr_en && addr == `OFF_WD_CTRL) begin
        wd_int_sel_r <= wdata[`WD_INT_SEL_BIT];
        wd_disable_r <= wdata[`WD_DISABLE_BIT];
      end
      if (wr_en && addr == `OFF_WD_WINDOW) begin
        wd_lower_r <= wdata[WD_W-1:0];
        wd_upper_r <= wdata[WD_W+15:16];
      end
    end
  end

  watchdog_window #(.CNT_W(WD_W)) watchdog_window_i (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .enable(!wd_disable_r),
    .key_wr(wr_en && addr == `OFF_WD_KEY),
    .key_data(wdata[7:0]),
    .lower(wd_lower_r),
    .upper(wd_upper_r),
    .int_select(wd_int_sel_r),
    .wd_irq_r(wd_irq),
    .wd_reset_r(wd_reset),
    .count(wd_count)
  );

  // ----------------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------------
  reg pll_lock_r_d;
  assign irq_event = {pll_lock_r && !pll_lock_r_d, wd_irq, |nmi_event};

  // set wins over clear
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_status_r <= {`IRQ_WIDTH{1'b0}};
      irq_enable_r <= {`IRQ_WIDTH{1'b0}};
      pll_lock_r_d <= 1'b0;
    end else begin
      pll_lock_r_d <= pll_lock_r;
      if (wr_en && addr == `OFF_IRQ_ENABLE) begin
        irq_enable_r <= wdata[`IRQ_WIDTH-1:0];
      end
      irq_status_r <= (irq_status_r &
        ~((wr_en && addr == `OFF_IRQ_CLEAR) ?
          wdata[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}})) | irq_event;
    end
  end

  assign irq = |(irq_status_r & irq_enable_r);

  // ----------------------------------------------------------------------
  // read mux, unmapped and write-only offsets read zero
  // ----------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 32'h00000000;
    end else if (rd_en) begin
      case (addr)
        `OFF_NMI_FLAG_SET: rdata_r <= {29'h0, nmi_flag_set_r};
        `OFF_NMI_SHADOW: rdata_r <= {29'h0, nmi_shadow_r};
        `OFF_CLK_GATE: rdata_r <= {{(32-N_PERIPH){1'b0}},
                                   periph_clock_gate_ctrl_r};
        `OFF_CLK_GATE_LOCK: rdata_r <= {31'h0, gate_lock_r};
        `OFF_SOFT_RESET: rdata_r <= {{(32-N_PERIPH){1'b0}},
                                     periph_soft_reset_ctrl_r};
        `OFF_RESET_CAUSE: rdata_r <= {27'h0, reset_cause_latch_r};
        `OFF_MISSING_CLK: rdata_r <= {29'h0, missing_clock_status_r,
                                      mcd_disable_r, osc_disconnect_r};
        `OFF_PLL_CTRL: rdata_r <= {29'h0, pll_lock_r, pll_ctrl_r};
        `OFF_WD_CTRL: rdata_r <= {{(24-WD_W){1'b0}}, wd_count,
                                  6'h00, wd_disable_r, wd_int_sel_r};
        `OFF_WD_WINDOW: rdata_r <= {{(16-WD_W){1'b0}}, wd_upper_r,
                                    {(16-WD_W){1'b0}}, wd_lower_r};
        `OFF_IRQ_STATUS: rdata_r <= {29'h0, irq_status_r};
        `OFF_IRQ_ENABLE: rdata_r <= {29'h0, irq_enable_r};
        default: rdata_r <= 32'h00000000;
      endcase
    end else begin
      rdata_r <= 32'h00000000;
    end
  end

endmodule // sysctl_reset_nmi_safety

/* File: sysctl_reset_nmi_safety_sva.sv */
// Purpose: port-level checks on the reset and nmi safety control block
// Assumes: warm reset rst_b disables every check
// Notes: bound into every instance of the control block
`include "sysctl_map.vh"

module sysctl_reset_nmi_safety_chk #(
  parameter N_PERIPH = 16
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata_r,
  input wire logic pll_freq_drift,
  input wire logic critical_error,
  input wire logic [N_PERIPH-1:0] periph_clk_en,
  input wire logic [N_PERIPH-1:0] periph_reset,
  input wire logic warm_reset_req_r,
  input wire logic pll_lock,
  input wire logic sysclk_on_pll,
  input wire logic error_status_pin,
  input wire logic nmi
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // checks, all in the core clock domain
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  rdata_idle_a: assert property (!$past(rd_en) |-> rdata_r == 32'h0)
    else $error("read data not zero outside a read answer");
  gate_write_only_a: assert property (
    !($past(wr_en) && $past(addr) == `OFF_CLK_GATE) |-> $stable(periph_clk_en))
    else $error("clock gate changed without a gate write");
  soft_write_only_a: assert property (
    !($past(wr_en) && $past(addr) == `OFF_SOFT_RESET) |-> $stable(periph_reset))
    else $error("soft reset changed without a soft reset write");
  force_pin_a: assert property (
    wr_en && addr == `OFF_NMI_FLAG_FORCE && wdata[`NMI_CLOCK_FAIL]
    |-> ##[1:2] error_status_pin)
    else $error("forced clock fail did not raise error pin");
  crit_pin_a: assert property (critical_error |-> ##[1:2] error_status_pin)
    else $error("critical error did not raise error pin");
  pin_follows_nmi_a: assert property (error_status_pin == nmi)
    else $error("error pin and nmi disagree");
  osc_off_nmi_a: assert property (
    wr_en && addr == `OFF_MISSING_CLK && wdata[0] && !wdata[1]
    |-> ##[1:4] nmi)
    else $error("oscillator off did not raise nmi");
  drift_unlock_a: assert property (pll_freq_drift |=> !pll_lock)
    else $error("lock stayed high during drift");
  switch_locked_a: assert property (sysclk_on_pll |-> pll_lock)
    else $error("system clock on pll without lock");
  sim_req_a: assert property (
    wr_en && addr == `OFF_SIM_RESET && wdata[1:0] != 2'h0
    |-> ##[1:20] warm_reset_req_r)
    else $error("simulated reset raised no warm request");
  req_hold_a: assert property (warm_reset_req_r |=> warm_reset_req_r)
    else $error("warm request dropped before reset");
endmodule // sysctl_reset_nmi_safety_chk

bind sysctl_reset_nmi_safety sysctl_reset_nmi_safety_chk #(
  .N_PERIPH(N_PERIPH)
) chk_i (.core_clk(core_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata_r(rdata_r),
  .pll_freq_drift(pll_freq_drift), .critical_error(critical_error),
  .periph_clk_en(periph_clk_en), .periph_reset(periph_reset),
  .warm_reset_req_r(warm_reset_req_r), .pll_lock(pll_lock),
  .sysclk_on_pll(sysclk_on_pll), .error_status_pin(error_status_pin),
  .nmi(nmi));

/* File: test_sysctl_reset_nmi_safety.sv */
// Purpose: self-checking bench for the reset and safety control block
// Assumes: bench plays the reset controller and answers warm requests
// Notes: watchdog window shrunk by software so expiry stays short
`include "sysctl_map.vh"

module test_sysctl_reset_nmi_safety;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_b, por_b, wr_en, rd_en, ext_pin_reset;
  logic pll_ref_clk_lost, pll_freq_drift, pll_locked_raw, critical_error;
  logic [7:0] addr;
  logic [31:0] wdata;
  wire [31:0] rdata_r;
  wire [15:0] periph_clk_en, periph_reset;
  wire warm_reset_req_r, external_reset_pin_oe_r, external_reset_pin_o;
  wire pll_lock, sysclk_on_pll, error_status_pin, nmi, irq;
  int failures, total_checks;

  sysctl_reset_nmi_safety #(.N_PERIPH(16), .WD_W(8))
    sysctl_reset_nmi_safety_i (
    .core_clk(core_clk), .rst_b(rst_b), .por_b(por_b), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_r(rdata_r),
    .ext_pin_reset(ext_pin_reset), .pll_ref_clk_lost(pll_ref_clk_lost),
    .pll_freq_drift(pll_freq_drift), .pll_locked_raw(pll_locked_raw),
    .critical_error(critical_error), .periph_clk_en(periph_clk_en),
    .periph_reset(periph_reset), .warm_reset_req_r(warm_reset_req_r),
    .external_reset_pin_oe_r(external_reset_pin_oe_r),
    .external_reset_pin_o(external_reset_pin_o), .pll_lock(pll_lock),
    .sysclk_on_pll(sysclk_on_pll), .error_status_pin(error_status_pin),
    .nmi(nmi), .irq(irq));

  // ------------------------------------------------------------------
  // clock and shared tasks
  // ------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report;
    if (failures == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input string what);
    @(posedge core_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 chk(what, exp, rdata_r);
  endtask

  // bounded wait on irq or on the warm reset request
  task automatic wait_for(input bit use_irq);
    int n;
    n = 0;
    #1; // the calling edge's updates must land before the first look
    while ((use_irq ? irq : warm_reset_req_r) !== 1'b1) begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > 1000) begin
        chk("wait_limit", 32'h1, 32'h0);
        final_report();
      end
    end
  endtask

  task automatic warm_pulse;
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset_values;
    rd(`OFF_CLK_GATE, 32'h0, "clk_gate_rst");
    chk("clk_en_rst", 32'h0, {16'h0, periph_clk_en});
    chk("soft_rst_rst", 32'h0, {16'h0, periph_reset});
    rd(`OFF_RESET_CAUSE, 32'h1, "cause_por");
    rd(`OFF_MISSING_CLK, 32'h0, "mcd_on");
    rd(8'h80, 32'h0, "unmapped");
  endtask

  task automatic t_gate_lock;
    wr(`OFF_CLK_GATE, 32'h00A5);
    #1 chk("clk_en_set", 32'h00A5, {16'h0, periph_clk_en});
    wr(`OFF_CLK_GATE_LOCK, 32'h1);
    wr(`OFF_CLK_GATE, 32'hFFFF);
    rd(`OFF_CLK_GATE, 32'h00A5, "clk_gate_locked");
    wr(`OFF_SOFT_RESET, 32'h3);
    #1 chk("soft_rst_set", 32'h3, {16'h0, periph_reset});
    wr(`OFF_SOFT_RESET, 32'h0);
  endtask

  // masked first, then enabled; clears are written only after the error source drops
  task automatic t_error_pin;
    wr(`OFF_NMI_FLAG_FORCE, 32'h1);
    repeat (2) @(posedge core_clk);
    #1 chk("err_pin_force", 32'h1, {31'h0, error_status_pin});
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(`OFF_IRQ_ENABLE, 32'h1);
    #1 chk("irq_on", 32'h1, {31'h0, irq});
    critical_error <= 1'b1;
    rd(`OFF_NMI_FLAG_SET, 32'h5, "nmi_flags");
    critical_error <= 1'b0;
    wr(`OFF_NMI_FLAG_CLEAR, 32'h7);
    wr(`OFF_IRQ_CLEAR, 32'h1);
    repeat (2) @(posedge core_clk);
    #1 chk("err_pin_clr", 32'h0, {31'h0, error_status_pin});
    chk("irq_clr", 32'h0, {31'h0, irq});
    wr(`OFF_IRQ_ENABLE, 32'h0);
  endtask

  task automatic t_missing_clk;
    wr(`OFF_MISSING_CLK, 32'h1);
    repeat (3) @(posedge core_clk);
    #1 chk("mcd_nmi", 32'h1, {31'h0, nmi});
    rd(`OFF_MISSING_CLK, 32'h5, "mcd_status");
    rd(`OFF_NMI_FLAG_SET, 32'h2, "mcd_flag");
    wr(`OFF_MISSING_CLK, 32'h0);
    wr(`OFF_MISSING_CLK, 32'h4);
    pll_ref_clk_lost <= 1'b1;
    rd(`OFF_MISSING_CLK, 32'h4, "mcd_ref_lost");
    pll_ref_clk_lost <= 1'b0;
    wr(`OFF_MISSING_CLK, 32'h4);
    wr(`OFF_NMI_FLAG_CLEAR, 32'h2);
    wr(`OFF_MISSING_CLK, 32'h2);
    pll_ref_clk_lost <= 1'b1;
    rd(`OFF_MISSING_CLK, 32'h2, "mcd_disable");
    pll_ref_clk_lost <= 1'b0;
    wr(`OFF_MISSING_CLK, 32'h0);
  endtask

  task automatic t_pll;
    @(posedge core_clk);
    pll_locked_raw <= 1'b1;
    wr(`OFF_PLL_CTRL, 32'h1);
    rd(`OFF_PLL_CTRL, 32'h5, "pll_locked");
    wr(`OFF_PLL_CTRL, 32'h3);
    #1 chk("on_pll", 32'h1, {31'h0, sysclk_on_pll});
    @(posedge core_clk);
    pll_freq_drift <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk("drift_lock", 32'h0, {31'h0, pll_lock});
    chk("drift_switch", 32'h0, {31'h0, sysclk_on_pll});
    @(posedge core_clk);
    pll_freq_drift <= 1'b0;
    pll_locked_raw <= 1'b0;
    wr(`OFF_PLL_CTRL, 32'h0);
  endtask

  task automatic t_sim_reset;
    wr(`OFF_NMI_FLAG_FORCE, 32'h1);
    wr(`OFF_SIM_RESET, 32'h1);
    wait_for(1'b0);
    chk("pin_idle", 32'h0, {31'h0, external_reset_pin_oe_r});
    warm_pulse();
    rd(`OFF_NMI_SHADOW, 32'h1, "shadow_kept");
    rd(`OFF_RESET_CAUSE, 32'h9, "cause_sim_sys");
    rd(`OFF_CLK_GATE, 32'h0, "gate_warm");
    wr(`OFF_RESET_CAUSE_CLR, 32'h1F);
    wr(`OFF_NMI_FLAG_CLEAR, 32'h7);
    wr(`OFF_SIM_RESET, 32'h2);
    wait_for(1'b0);
    chk("pin_drive", 32'h1, {31'h0, external_reset_pin_oe_r});
    chk("pin_low", 32'h0, {31'h0, external_reset_pin_o});
    warm_pulse();
    rd(`OFF_RESET_CAUSE, 32'h10, "cause_sim_ext");
    wr(`OFF_RESET_CAUSE_CLR, 32'h1F);
    ext_pin_reset <= 1'b1;
    warm_pulse();
    ext_pin_reset <= 1'b0;
    rd(`OFF_RESET_CAUSE, 32'h2, "cause_pin");
  endtask

  // bad key, expiry in interrupt mode, then expiry in reset mode
  task automatic t_watchdog;
    wr(`OFF_IRQ_CLEAR, 32'h7);
    wr(`OFF_WD_WINDOW, 32'h00030002);
    wr(`OFF_WD_CTRL, 32'h1);
    wr(`OFF_IRQ_ENABLE, 32'h2);
    wr(`OFF_WD_KEY, 32'h12);
    repeat (3) @(posedge core_clk);
    #1 chk("wd_bad_key", 32'h1, {31'h0, irq});
    wr(`OFF_IRQ_CLEAR, 32'h2);
    // service while the count is still under the lower bound
    wr(`OFF_WD_KEY, {24'h0, `WD_KEY_FIRST});
    wr(`OFF_WD_KEY, {24'h0, `WD_KEY_SECOND});
    repeat (3) @(posedge core_clk);
    #1 chk("wd_early", 32'h1, {31'h0, irq});
    wr(`OFF_IRQ_CLEAR, 32'h2);
    wait_for(1'b1);
    rd(`OFF_IRQ_STATUS, 32'h2, "wd_status");
    chk("wd_no_reset", 32'h0, {31'h0, warm_reset_req_r});
    wr(`OFF_IRQ_ENABLE, 32'h0);
    wr(`OFF_NMI_FLAG_FORCE, 32'h1);
    wr(`OFF_WD_CTRL, 32'h0);
    wait_for(1'b0);
    warm_pulse();
    rd(`OFF_NMI_SHADOW, 32'h1, "shadow_wd");
    rd(`OFF_RESET_CAUSE, 32'h6, "cause_wd");
  endtask

  task automatic t_cold;
    @(posedge core_clk);
    por_b <= 1'b0;
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    por_b <= 1'b1;
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(`OFF_NMI_SHADOW, 32'h0, "shadow_cold");
    rd(`OFF_RESET_CAUSE, 32'h1, "cause_cold");
  endtask

  initial begin
    failures = 0;
    total_checks = 0;
    rst_b = 1'b0;
    por_b = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    ext_pin_reset = 1'b0;
    pll_ref_clk_lost = 1'b0;
    pll_freq_drift = 1'b0;
    pll_locked_raw = 1'b0;
    critical_error = 1'b0;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    t_reset_values();
    t_gate_lock();
    t_error_pin();
    t_missing_clk();
    t_pll();
    t_sim_reset();
    t_watchdog();
    t_cold();
    final_report();
  end
endmodule // test_sysctl_reset_nmi_safety

/* File: watchdog_window.v */
// Purpose: internal windowed watchdog with interrupt or reset response
// Assumes: key writes arrive as single-cycle strobes
// Notes: counter runs from zero upward after each good service

`include "sysctl_map.vh"

module watchdog_window #(
  parameter CNT_W = 8
) (
  input wire core_clk,
  input wire rst_b,
  input wire enable,
  input wire key_wr,
  input wire [7:0] key_data,
  input wire [CNT_W-1:0] lower,
  input wire [CNT_W-1:0] upper,
  input wire int_select,
  output reg wd_irq_r,
  output reg wd_reset_r,
  output wire [CNT_W-1:0] count
);

  reg [7:0] pre_r;
  reg [CNT_W-1:0] cnt_r;
  reg armed_r;
  wire tick = (pre_r == `WD_PRESCALE - 8'h01);
  wire early = key_wr && key_data == `WD_KEY_SECOND && armed_r &&
               cnt_r < lower;
  wire bad_key = key_wr && key_data != `WD_KEY_FIRST &&
                 key_data != `WD_KEY_SECOND;
  wire expired = tick && (cnt_r >= upper);
  wire fail = enable && (early || bad_key || expired);

  assign count = cnt_r;

  // ----------------------------------------------------------------------
  // counting and servicing
  // ----------------------------------------------------------------------
  // window service check
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_r <= 8'h00;
      cnt_r <= {CNT_W{1'b0}};
      armed_r <= 1'b0;
    end else begin
      pre_r <= tick ? 8'h00 : pre_r + 8'h01;
      if (!enable || fail) begin
        cnt_r <= {CNT_W{1'b0}};
        armed_r <= 1'b0;
      end else if (key_wr && key_data == `WD_KEY_FIRST) begin
        armed_r <= 1'b1;
      end else if (key_wr && key_data == `WD_KEY_SECOND && armed_r) begin
        cnt_r <= {CNT_W{1'b0}}; // good service inside window
        armed_r <= 1'b0;
      end else if (tick) begin
        cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_irq_r <= 1'b0;
      wd_reset_r <= 1'b0;
    end else begin
      wd_irq_r <= fail && int_select;
      wd_reset_r <= fail && !int_select;
    end
  end

endmodule // watchdog_window
